// ---- include/fpfl_regs.vh ----
`ifndef FPFL_REGS_VH
`define FPFL_REGS_VH

// Clock and protection timing
`define FPFL_CLK_PERIOD_NS 4
`define FPFL_SUPPLY_QUAL_NS 10000
`define FPFL_THERMAL_QUAL_NS 10000
`define FPFL_FAULT_HI_BLANK_NS 50000
`define FPFL_FAULT_LO_BLANK_NS 350000
`define FPFL_SLEEP_QUAL_NS 500000000
`define FPFL_SHORT_PULSES 3'd4
`define FPFL_OVERLOAD_CYC_DEF 50000
`define FPFL_RESTART_CYC_DEF 250000

// Register byte offsets
`define FPFL_CTRL_OFS 12'h000
`define FPFL_STATUS_OFS 12'h004
`define FPFL_EVENT_OFS 12'h008

// Control fields
`define FPFL_CTRL_OVL_AUTOREC 0
`define FPFL_CTRL_FAULT_AUTOREC 1
`define FPFL_CTRL_RST 2'h0

// Latch cause positions (status and event)
`define FPFL_C_OVL 0
`define FPFL_C_DUTY 1
`define FPFL_C_SHORT 2
`define FPFL_C_UVLO 3
`define FPFL_C_OVP 4
`define FPFL_C_FHI 5
`define FPFL_C_FLO 6
`define FPFL_CAUSE_W 7

// Stop cause positions, placed above the latch causes
`define FPFL_S_BROWN 0
`define FPFL_S_TSD 1
`define FPFL_S_SLEEP 2
`define FPFL_STOP_W 3
`define FPFL_STOP_LSB 7
`define FPFL_STATE_LSB 10

`endif

// ---- hw/fpfl_qual.v ----
`timescale 1ns/1ns
`default_nettype none
// Level qualifier: hit_reg rises after level has held for limit cycles
module fpfl_qual #(
	parameter W = 32
) (
	// Clock and reset
	input wire mclk,
	input wire nrst,
	input wire ce,
	// Control
	input wire clr,
	input wire level,
	input wire [W-1:0] limit,
	// Result
	output reg hit_reg
);
	reg [W-1:0] cnt_reg;
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= {W{1'b0}};
			hit_reg <= 1'b0;
		end else if (ce) begin
			if (clr || !level) begin
				cnt_reg <= {W{1'b0}};
				hit_reg <= 1'b0;
			end else if (cnt_reg == limit - {{(W-1){1'b0}}, 1'b1}) begin
				hit_reg <= 1'b1;
			end else if (!hit_reg) begin
				cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule
`default_nettype wire

// ---- hw/fpfl_top.v ----
// Summary of operation
// - Current limit runs overload timer, expiry latches
// - Limit released early clears overload timer
// - On-time or duty limit latches; brown-out release
// - Autorecovery variant restarts after restart delay
// - Brown-out or power-on reset releases latch
// - Four consecutive winding-short pulses latch
// - Restart needs line start and supply on
// - Qualified thermal shutdown stops drive and startup source
// - Fault input outside window latches off
// - Fault excursions blanked 50us high, 350us low
// - Fault latch autorecovery is a version option
// - Fault high ignored until supply reaches on
// - Fault low ignored until soft-start done
// - Thermistor bias doubled during soft-start
// - Thermal trip stops at once, supply kept
// - Thermal clear re-enables normal startup
`timescale 1ns/1ns
`default_nettype none
`include "fpfl_regs.vh"
module fpfl_top #(
	parameter OVERLOAD_CYC = `FPFL_OVERLOAD_CYC_DEF,
	parameter RESTART_CYC = `FPFL_RESTART_CYC_DEF,
	parameter FAULT_HI_CYC = (`FPFL_FAULT_HI_BLANK_NS + `FPFL_CLK_PERIOD_NS - 1)
		/ `FPFL_CLK_PERIOD_NS,
	parameter FAULT_LO_CYC = (`FPFL_FAULT_LO_BLANK_NS + `FPFL_CLK_PERIOD_NS - 1)
		/ `FPFL_CLK_PERIOD_NS,
	parameter SLEEP_CYC = `FPFL_SLEEP_QUAL_NS / `FPFL_CLK_PERIOD_NS,
	parameter [1:0] CTRL_RESET = `FPFL_CTRL_RST
) (
	// Clock, reset, enable
	input wire mclk,
	input wire nrst,
	input wire ce,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Current sense and pulse events
	input wire pwm_request,
	input wire pulse_end,
	input wire drive_limit_end,
	input wire cs_at_limit,
	input wire cs_winding_short,
	// Supply, line and feedback comparators
	input wire vcc_below_off,
	input wire vcc_above_on,
	input wire vcc_above_ovp,
	input wire line_above_start,
	input wire line_below_stop,
	input wire feedback_below_sleep,
	input wire feedback_above_wake,
	// Thermal and fault input comparators
	input wire thermal_shutdown,
	input wire thermal_shutdown_clear,
	input wire fault_above_high,
	input wire fault_below_low,
	input wire soft_start_done,
	// Outputs to power stage and analog blocks
	output wire gate_drive_out,
	output wire soft_start_run,
	output wire thermistor_bias_boosted,
	output wire hv_source_enable,
	output wire internal_supply_enable
);
	localparam SUPPLY_CYC = (`FPFL_SUPPLY_QUAL_NS + `FPFL_CLK_PERIOD_NS - 1)
		/ `FPFL_CLK_PERIOD_NS;
	localparam THERMAL_CYC = (`FPFL_THERMAL_QUAL_NS + `FPFL_CLK_PERIOD_NS - 1)
		/ `FPFL_CLK_PERIOD_NS;
	localparam [4:0] ST_OFF = 5'h01;
	localparam [4:0] ST_SOFT = 5'h02;
	localparam [4:0] ST_RUN = 5'h04;
	localparam [4:0] ST_LATCH = 5'h08;
	localparam [4:0] ST_STOP = 5'h10;

	reg [4:0] state_reg, state_next;
	reg [`FPFL_CAUSE_W-1:0] cause_reg, cause_next;
	reg [`FPFL_STOP_W-1:0] stop_reg, stop_next;
	reg [`FPFL_CAUSE_W+`FPFL_STOP_W-1:0] event_reg, event_next;
	reg [1:0] ctrl_reg;
	reg [2:0] short_cnt_reg;
	reg short_seen_reg, duty_active_reg, fhi_armed_reg;
	reg gate_reg, soft_reg, boost_reg, hv_reg, vint_reg;
	reg [31:0] prdata_reg;
	reg pready_reg, pslverr_reg;

	wire ovl_hit, duty_hit, uvlo_hit, ovp_hit, tsd_hit, fhi_hit, flo_hit;
	wire sleep_hit, restart_hit;
	wire active = (state_reg == ST_SOFT) || (state_reg == ST_RUN);
	wire short_now = short_seen_reg || cs_winding_short;
	wire short_trip = active && pulse_end && short_now
		&& (short_cnt_reg == `FPFL_SHORT_PULSES - 3'd1);
	wire [`FPFL_CAUSE_W-1:0] new_cause;
	wire [`FPFL_CAUSE_W-1:0] auto_mask;
	wire auto_ok = (cause_reg != {`FPFL_CAUSE_W{1'b0}})
		&& ((cause_reg & ~auto_mask) == {`FPFL_CAUSE_W{1'b0}});
	// A thermal or sleep stop also waits for its own clear condition
	wire restart_ok = line_above_start && vcc_above_on
		&& (!stop_reg[`FPFL_S_TSD] || thermal_shutdown_clear)
		&& (!stop_reg[`FPFL_S_SLEEP] || feedback_above_wake);
	wire apb_go = psel && penable && pready_reg;

	// Overcurrent, winding short and low supply share the overload variant bit
	assign auto_mask[`FPFL_C_OVL] = ctrl_reg[`FPFL_CTRL_OVL_AUTOREC];
	assign auto_mask[`FPFL_C_DUTY] = 1'b0;
	assign auto_mask[`FPFL_C_SHORT] = ctrl_reg[`FPFL_CTRL_OVL_AUTOREC];
	assign auto_mask[`FPFL_C_UVLO] = ctrl_reg[`FPFL_CTRL_OVL_AUTOREC];
	assign auto_mask[`FPFL_C_OVP] = 1'b0;
	assign auto_mask[`FPFL_C_FHI] = ctrl_reg[`FPFL_CTRL_FAULT_AUTOREC];
	assign auto_mask[`FPFL_C_FLO] = ctrl_reg[`FPFL_CTRL_FAULT_AUTOREC];

	assign new_cause[`FPFL_C_OVL] = ovl_hit;
	assign new_cause[`FPFL_C_DUTY] = duty_hit;
	assign new_cause[`FPFL_C_SHORT] = short_trip;
	assign new_cause[`FPFL_C_UVLO] = uvlo_hit;
	assign new_cause[`FPFL_C_OVP] = ovp_hit;
	assign new_cause[`FPFL_C_FHI] = fhi_hit;
	assign new_cause[`FPFL_C_FLO] = flo_hit;

	// Qualifier resets on level loss, so a short limit excursion leaves no trace
	fpfl_qual u_ovl (.mclk(mclk), .nrst(nrst), .ce(ce), .clr(!active),
		.level(cs_at_limit), .limit(OVERLOAD_CYC), .hit_reg(ovl_hit));
	fpfl_qual u_duty (.mclk(mclk), .nrst(nrst), .ce(ce), .clr(!active),
		.level(duty_active_reg), .limit(OVERLOAD_CYC), .hit_reg(duty_hit));
	fpfl_qual u_uvlo (.mclk(mclk), .nrst(nrst), .ce(ce), .clr(!active),
		.level(vcc_below_off), .limit(SUPPLY_CYC), .hit_reg(uvlo_hit));
	fpfl_qual u_ovp (.mclk(mclk), .nrst(nrst), .ce(ce), .clr(!active),
		.level(vcc_above_ovp), .limit(SUPPLY_CYC), .hit_reg(ovp_hit));
	fpfl_qual u_tsd (.mclk(mclk), .nrst(nrst), .ce(ce), .clr(1'b0),
		.level(thermal_shutdown), .limit(THERMAL_CYC), .hit_reg(tsd_hit));
	fpfl_qual u_fhi (.mclk(mclk), .nrst(nrst), .ce(ce), .clr(!fhi_armed_reg),
		.level(fault_above_high), .limit(FAULT_HI_CYC), .hit_reg(fhi_hit));
	fpfl_qual u_flo (.mclk(mclk), .nrst(nrst), .ce(ce), .clr(state_reg != ST_RUN),
		.level(fault_below_low), .limit(FAULT_LO_CYC), .hit_reg(flo_hit));
	fpfl_qual u_sleep (.mclk(mclk), .nrst(nrst), .ce(ce), .clr(state_reg != ST_RUN),
		.level(feedback_below_sleep), .limit(SLEEP_CYC), .hit_reg(sleep_hit));
	fpfl_qual u_restart (.mclk(mclk), .nrst(nrst), .ce(ce), .clr(state_reg != ST_LATCH),
		.level(auto_ok), .limit(RESTART_CYC), .hit_reg(restart_hit));

	always @* begin
		state_next = state_reg;
		cause_next = cause_reg;
		stop_next = stop_reg;
		// Brown-out outranks thermal, thermal outranks sleep and latch
		if (line_below_stop) begin
			state_next = ST_STOP;
			cause_next = {`FPFL_CAUSE_W{1'b0}};
			stop_next = stop_reg | (3'h1 << `FPFL_S_BROWN);
		end else if (tsd_hit) begin
			state_next = ST_STOP;
			stop_next = stop_reg | (3'h1 << `FPFL_S_TSD);
		end else begin
			case (state_reg)
				ST_OFF: begin
					if (vcc_above_on && line_above_start && !fhi_hit
						&& !fault_above_high) begin
						state_next = ST_SOFT;
					end else if (fhi_hit) begin
						state_next = ST_LATCH;
						cause_next = cause_reg | new_cause;
					end
				end
				ST_SOFT, ST_RUN: begin
					if (new_cause != {`FPFL_CAUSE_W{1'b0}}) begin
						state_next = ST_LATCH;
						cause_next = cause_reg | new_cause;
					end else if (sleep_hit) begin
						state_next = ST_STOP;
						stop_next = stop_reg | (3'h1 << `FPFL_S_SLEEP);
					end else if (state_reg == ST_SOFT && soft_start_done) begin
						state_next = ST_RUN;
					end
				end
				ST_LATCH: begin
					if (restart_hit) begin
						state_next = ST_OFF;
						cause_next = {`FPFL_CAUSE_W{1'b0}};
					end
				end
				ST_STOP: begin
					if (restart_ok) begin
						state_next = ST_OFF;
						stop_next = {`FPFL_STOP_W{1'b0}};
					end
				end
				default: begin
					state_next = ST_OFF;
				end
			endcase
		end
	end

	// Sticky events: a new event wins over a same-cycle software clear
	always @* begin
		event_next = event_reg;
		if (apb_go && pwrite && paddr == `FPFL_EVENT_OFS) begin
			event_next = event_reg & ~pwdata[`FPFL_CAUSE_W+`FPFL_STOP_W-1:0];
		end
		event_next = event_next | {stop_next & ~stop_reg, cause_next & ~cause_reg};
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_OFF;
			cause_reg <= {`FPFL_CAUSE_W{1'b0}};
			stop_reg <= {`FPFL_STOP_W{1'b0}};
			short_cnt_reg <= 3'h0;
			short_seen_reg <= 1'b0;
			duty_active_reg <= 1'b0;
			fhi_armed_reg <= 1'b0;
			gate_reg <= 1'b0;
			soft_reg <= 1'b0;
			boost_reg <= 1'b0;
			hv_reg <= 1'b1;
			vint_reg <= 1'b1;
		end else if (ce) begin
			state_reg <= state_next;
			cause_reg <= cause_next;
			stop_reg <= stop_next;
			if (!active || pulse_end) begin
				short_seen_reg <= 1'b0;
			end else if (cs_winding_short) begin
				short_seen_reg <= 1'b1;
			end
			if (!active) begin
				short_cnt_reg <= 3'h0;
			end else if (pulse_end) begin
				short_cnt_reg <= short_now ? short_cnt_reg + 3'h1 : 3'h0;
			end
			if (!active) begin
				duty_active_reg <= 1'b0;
			end else if (pulse_end) begin
				duty_active_reg <= drive_limit_end;
			end
			if (state_next == ST_STOP) begin
				fhi_armed_reg <= 1'b0;
			end else if (vcc_above_on) begin
				fhi_armed_reg <= 1'b1;
			end
			gate_reg <= pwm_request && (state_next == ST_SOFT || state_next == ST_RUN)
				&& (state_reg == ST_SOFT || state_reg == ST_RUN);
			soft_reg <= (state_next == ST_SOFT);
			boost_reg <= (state_next == ST_SOFT);
			hv_reg <= !stop_next[`FPFL_S_TSD];
			vint_reg <= !stop_next[`FPFL_S_SLEEP];
		end
	end

	// APB slave with one wait state; answers come from registers
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			// Version strap picks the release option; zero is the fully latched variant
			ctrl_reg <= CTRL_RESET;
			event_reg <= {(`FPFL_CAUSE_W+`FPFL_STOP_W){1'b0}};
			prdata_reg <= 32'h00000000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else if (ce) begin
			event_reg <= event_next;
			pready_reg <= psel && penable && !pready_reg;
			if (apb_go && pwrite && paddr == `FPFL_CTRL_OFS) begin
				ctrl_reg <= pwdata[1:0];
			end
			if (psel && penable && !pready_reg) begin
				pslverr_reg <= !(paddr == `FPFL_CTRL_OFS || paddr == `FPFL_STATUS_OFS
					|| paddr == `FPFL_EVENT_OFS);
				case (paddr)
					`FPFL_CTRL_OFS: prdata_reg <= {30'h0, ctrl_reg};
					`FPFL_STATUS_OFS: prdata_reg <= {17'h0, state_reg, stop_reg, cause_reg};
					`FPFL_EVENT_OFS: prdata_reg <= {22'h0, event_reg};
					default: prdata_reg <= 32'h00000000;
				endcase
			end else begin
				pslverr_reg <= 1'b0;
				prdata_reg <= 32'h00000000;
			end
		end
	end

	// Every output leaves straight from a flip-flop, so the pins never glitch

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign gate_drive_out = gate_reg;
	assign soft_start_run = soft_reg;
	assign thermistor_bias_boosted = boost_reg;
	assign hv_source_enable = hv_reg;
	assign internal_supply_enable = vint_reg;
endmodule
`default_nettype wire

// ---- testbench/fpfl_top_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module fpfl_top_monitor #(
	parameter OVERLOAD_CYC = 20
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Watched inputs
	input wire logic pwm_request,
	input wire logic cs_at_limit,
	input wire logic line_below_stop,
	input wire logic line_above_start,
	input wire logic vcc_above_on,
	input wire logic thermal_shutdown,
	// Watched outputs
	input wire logic gate_drive_out,
	input wire logic soft_start_run,
	input wire logic thermistor_bias_boosted,
	input wire logic hv_source_enable,
	input wire logic internal_supply_enable
);
	logic [11:0] lim_reg;
	logic [11:0] hot_reg;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Counts saturate so a long hold never wraps into a false match
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lim_reg <= 12'h000;
			hot_reg <= 12'h000;
		end else begin
			lim_reg <= cs_at_limit ? lim_reg + {11'h000, lim_reg != 12'hFFF} : 12'h000;
			hot_reg <= thermal_shutdown ? hot_reg + {11'h000, hot_reg != 12'hFFF} : 12'h000;
		end
	end
	chk_pulse_needs_req: assert property ($rose(gate_drive_out) |-> $past(pwm_request))
		else $error("gate pulse without request");
	chk_overload_stops: assert property (lim_reg == OVERLOAD_CYC + 3 |-> !gate_drive_out)
		else $error("gate still on after overload time");
	chk_brown_stops: assert property (line_below_stop [*2] |=> !gate_drive_out)
		else $error("gate on during brown-out");
	chk_tsd_source_off: assert property ($fell(hv_source_enable) |-> $past(hot_reg, 4) >= 12'd2000)
		else $error("startup source off without qualified thermal trip");
	chk_tsd_gate_low: assert property (!hv_source_enable |=> !gate_drive_out)
		else $error("gate on in thermal stop");
	chk_sleep_gate_low: assert property (!internal_supply_enable |=> !gate_drive_out)
		else $error("gate on while supply is off");
	chk_boost_in_soft: assert property (thermistor_bias_boosted == soft_start_run)
		else $error("bias boost differs from soft-start");
	chk_start_needs_on: assert property ($rose(soft_start_run) |-> $past(vcc_above_on) && $past(line_above_start))
		else $error("start without supply and line");
endmodule
bind fpfl_top fpfl_top_monitor #(.OVERLOAD_CYC(OVERLOAD_CYC)) i_fpfl_top_monitor (
	.mclk(mclk), .nrst(nrst), .pwm_request(pwm_request), .cs_at_limit(cs_at_limit),
	.line_below_stop(line_below_stop), .line_above_start(line_above_start),
	.vcc_above_on(vcc_above_on), .thermal_shutdown(thermal_shutdown),
	.gate_drive_out(gate_drive_out), .soft_start_run(soft_start_run),
	.thermistor_bias_boosted(thermistor_bias_boosted), .hv_source_enable(hv_source_enable),
	.internal_supply_enable(internal_supply_enable)
);
`default_nettype wire

// ---- testbench/fpfl_sense_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module fpfl_sense_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Gate and test mode
	input wire logic gate_drive_out,
	input wire logic [1:0] mode,
	// Sense and pulse events
	output logic pwm_request,
	output logic pulse_end,
	output logic drive_limit_end,
	output logic cs_winding_short
);
	logic [2:0] phase_reg;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			phase_reg <= 3'h0;
		end else begin
			phase_reg <= phase_reg + 3'h1;
		end
	end
	// Fixed half-duty request; a pulse ends only if the gate really was on
	assign pwm_request = !phase_reg[2];
	assign pulse_end = gate_drive_out && phase_reg == 3'h4;
	// Mode 1 shorts the winding, mode 2 ends every pulse on the on-time limit
	assign drive_limit_end = pulse_end && mode == 2'h2;
	assign cs_winding_short = gate_drive_out && mode == 2'h1;
endmodule
`default_nettype wire

// ---- testbench/fpfl_top_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) \
	begin \
		compares++; \
		if ((g) !== (e)) begin \
			fail_count++; \
			$display("Error %s expected %0h seen %0h", n, e, g); \
		end \
	end
module fpfl_top_tb;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic line_above_start = 1'b0;
	logic vcc_above_on = 1'b0;
	logic line_below_stop = 1'b0;
	logic soft_start_done = 1'b0;
	logic [7:0] ev = 8'h00;
	logic [1:0] mode = 2'h0;
	logic [31:0] prdata;
	logic pready, pslverr, gate_drive_out, soft_start_run, thermistor_bias_boosted;
	logic hv_source_enable, internal_supply_enable;
	logic pwm_request, pulse_end, drive_limit_end, cs_winding_short;
	logic [31:0] r;
	logic e;
	logic g;
	int fail_count = 0;
	int compares = 0;
	int tick = 0;
	// Per case: overload, duty, short, low and high supply, fault high/low, thermal, sleep
	// Holds end well inside the restart delay, so the latch is still seen when read
	int hold[9] = '{40, 60, 60, 2520, 2520, 40, 40, 2600, 60};
	int miss[9] = '{10, 10, 12, 1200, 1200, 12, 20, 1200, 30};
	logic [14:0] st[9] = '{15'h2001, 15'h2002, 15'h2004, 15'h2008, 15'h2010, 15'h2020,
		15'h2040, 15'h4100, 15'h4200};
	logic [8:0] ar = 9'h1ED;
	logic [8:0] hvm = 9'h17F;
	logic [8:0] intm = 9'h0FF;
	fpfl_top #(.OVERLOAD_CYC(20), .RESTART_CYC(80), .FAULT_HI_CYC(16), .FAULT_LO_CYC(24),
		.SLEEP_CYC(40)) i_fpfl_top (
		.mclk(mclk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pwm_request(pwm_request), .pulse_end(pulse_end), .drive_limit_end(drive_limit_end),
		.cs_at_limit(ev[0]), .cs_winding_short(cs_winding_short), .vcc_below_off(ev[1]),
		.vcc_above_on(vcc_above_on), .vcc_above_ovp(ev[2]), .line_above_start(line_above_start),
		.line_below_stop(line_below_stop), .feedback_below_sleep(ev[6]),
		.feedback_above_wake(!ev[6]), .thermal_shutdown(ev[5]), .thermal_shutdown_clear(!ev[5]),
		.fault_above_high(ev[3]), .fault_below_low(ev[4]), .soft_start_done(soft_start_done),
		.gate_drive_out(gate_drive_out), .soft_start_run(soft_start_run),
		.thermistor_bias_boosted(thermistor_bias_boosted), .hv_source_enable(hv_source_enable),
		.internal_supply_enable(internal_supply_enable)
	);
	fpfl_sense_model i_fpfl_sense_model (
		.mclk(mclk), .nrst(nrst), .gate_drive_out(gate_drive_out), .mode(mode),
		.pwm_request(pwm_request), .pulse_end(pulse_end), .drive_limit_end(drive_limit_end),
		.cs_winding_short(cs_winding_short)
	);
	initial begin
		forever #2 mclk = ~mclk;
	end
	task automatic finish_test();
		if (fail_count == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		tick++;
		if (tick == 60000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic gsee();
		g = 1'b0;
		repeat (16) begin
			@(posedge mclk);
			g = g | gate_drive_out;
		end
	endtask
	// Brown-out pulse releases any latch, then a full soft-start into run
	task automatic go_run();
		@(posedge mclk);
		line_below_stop <= 1'b1;
		cyc(3);
		line_below_stop <= 1'b0;
		cyc(8);
		`CHK("soft start", 2'h3, {soft_start_run, thermistor_bias_boosted})
		soft_start_done <= 1'b1;
		cyc(1);
		soft_start_done <= 1'b0;
		cyc(3);
		`CHK("boost off", 1'b0, thermistor_bias_boosted)
		gsee();
		`CHK("running", 1'b1, g)
	endtask
	task automatic trip(input int i, input int n);
		@(posedge mclk);
		ev <= (i == 0) ? 8'h01 : (i > 2) ? 8'h01 << (i - 2) : 8'h00;
		mode <= (i == 1) ? 2'h2 : (i == 2) ? 2'h1 : 2'h0;
		cyc(n);
	endtask
	initial begin
		cyc(6);
		`CHK("reset outs", 3'h3, {gate_drive_out, hv_source_enable, internal_supply_enable})
		nrst <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		`CHK("ctrl reset", 32'h0, r)
		apb(1'b1, 12'h000, 32'h3);
		apb(1'b0, 12'h000, 32'h0);
		`CHK("ctrl", 32'h3, r)
		apb(1'b0, 12'h00C, 32'h0);
		`CHK("unmapped", 33'h100000000, {e, r})
		line_above_start <= 1'b1;
		vcc_above_on <= 1'b1;
		for (int p = 0; p < 2; p++) begin
			apb(1'b1, 12'h000, p ? 32'h3 : 32'h0);
			for (int i = 0; i < 9; i++) begin
				go_run();
				trip(i, miss[i]);
				ev <= 8'h00;
				mode <= 2'h0;
				cyc(20);
				apb(1'b0, 12'h004, 32'h0);
				`CHK("blanked", 15'h1000, r[14:0])
				trip(i, hold[i]);
				apb(1'b0, 12'h004, 32'h0);
				`CHK("cause", st[i], r[14:0])
				`CHK("supplies", {hvm[i], intm[i]}, {hv_source_enable, internal_supply_enable})
				gsee();
				`CHK("gate held", 1'b0, g)
				ev <= 8'h00;
				mode <= 2'h0;
				cyc(60);
				apb(1'b0, 12'h004, 32'h0);
				`CHK("release", st[i][13] & ~(p[0] & ar[i]), r[13])
			end
		end
		apb(1'b0, 12'h008, 32'h0);
		`CHK("events", 32'h3FF, r)
		apb(1'b1, 12'h008, 32'h3FF);
		apb(1'b0, 12'h008, 32'h0);
		`CHK("events cleared", 32'h0, r)
		// Gate toggles in soft-start; with the enable low it must not move
		@(posedge mclk);
		ce <= 1'b0;
		cyc(2);
		e = gate_drive_out;
		g = 1'b0;
		repeat (16) begin
			@(posedge mclk);
			g = g | (gate_drive_out !== e);
		end
		ce <= 1'b1;
		`CHK("frozen", 1'b0, g)
		finish_test();
	end
endmodule
`default_nettype wire
